//--- src/apr_pkg.sv
// Constants for the primary audio port pin and clock routing block.
// Assumes an 8-bit paged register port and a single 250 MHz clock.
package apr_pkg;

    // ****************************************************************
    // Register addresses and page
    // ****************************************************************
    localparam logic [6:0] APR_ADDR_PAGE       = 7'h00;
    localparam logic [6:0] APR_ADDR_BIT_CLOCK  = 7'h08;
    localparam logic [6:0] APR_ADDR_WORD_CLOCK = 7'h09;
    localparam logic [6:0] APR_ADDR_DATA_PIN   = 7'h0C;
    localparam logic [6:0] APR_ADDR_DIV_SRC    = 7'h0D;
    localparam logic [6:0] APR_ADDR_DIV_RATIO  = 7'h0E;
    localparam logic [7:0] APR_ROUTING_PAGE    = 8'h01;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int APR_PIN_SEL_LSB   = 3;
    localparam int APR_PIN_SEL_MSB   = 6;
    localparam int APR_POLARITY_BIT  = 1;
    localparam int APR_FREE_RUN_BIT  = 0;
    localparam int APR_OUT_SRC_LSB   = 0;
    localparam int APR_OUT_SRC_MSB   = 1;
    localparam int APR_DIV_SRC_LSB   = 0;
    localparam int APR_DIV_SRC_MSB   = 2;
    localparam int APR_RATIO_LSB     = 0;
    localparam int APR_RATIO_MSB     = 6;
    localparam int APR_DIV_PWR_BIT   = 7;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] APR_RST_PAGE       = 8'h01;
    localparam logic [3:0] APR_RST_BIT_PIN    = 4'h0;
    localparam logic [3:0] APR_RST_WORD_PIN   = 4'h1;
    localparam logic [3:0] APR_RST_DATA_PIN   = 4'h0;
    localparam logic [1:0] APR_RST_OUT_SRC    = 2'h0;
    localparam logic [2:0] APR_RST_DIV_SRC    = 3'h1;
    localparam logic [6:0] APR_RST_RATIO      = 7'h02;
    localparam logic       APR_RST_DIV_PWR    = 1'b0;
    localparam logic [7:0] APR_RST_WORD_REG   = 8'h08;

    // ****************************************************************
    // Codes
    // ****************************************************************
    localparam logic [3:0] APR_PIN_GPIO_LAST  = 4'h9;
    localparam logic [3:0] APR_PIN_GPI_FIRST  = 4'hC;
    localparam logic [3:0] APR_PIN_GPI_LAST   = 4'hE;
    localparam logic [7:0] APR_DIV_FULL       = 8'h80;

    typedef enum logic [1:0] {
        APR_OUT_NORMAL_SENSE,
        APR_OUT_LOOP_PRIMARY,
        APR_OUT_LOOP_SECONDARY,
        APR_OUT_NORMAL_CONFIG
    } apr_out_src_t;

    typedef enum logic [2:0] {
        APR_DIV_PLL,
        APR_DIV_DAC_MOD,
        APR_DIV_RSVD2,
        APR_DIV_ADC_MOD,
        APR_DIV_PRIMARY_PIN,
        APR_DIV_RSVD5,
        APR_DIV_SECONDARY_PIN,
        APR_DIV_RSVD7
    } apr_div_src_t;

endpackage : apr_pkg

//--- src/apr_routing.sv
// Pin and clock routing for the primary audio port, with its paged registers.
// Assumes pin inputs are asynchronous and on-chip clocks are sampled levels
// of the I_MCLK domain.
//
// Notes on behaviour
// [R1] Bit clock comes from pin chosen by bits 6-3; GPIO codes 0-9, GPI 12-14.
// [R2] Bit clock selector resets to code 0, general I/O pin 0.
// [R3] Bit 1 of bit clock register inverts the bit clock when set; resets 0.
// [R4] Clocks drive only when port active and codec powered, unless free-run set.
// [R5] Word clock pin chosen by bits 6-3, same codes; resets to code 1.
// [R6] Bit 1 of word clock register inverts the word clock when set; resets 0.
// [R7] Serial input pin chosen by bits 6-3, same codes; resets to code 0.
// [R8] Output codes 0 and 3 send normal path; enable by sensing or config.
// [R9] Output code 1 loops primary serial input, code 2 the secondary input.
// [R10] Divider source in bits 2-0: PLL, DAC, ADC, port pins; resets to 1.
// [R11] Word clock register resets to 8h.
// [R12] Host selects page 1 through address zero before touching these registers.
// [R13] Divider divides by seven-bit ratio; ratio zero means 128.
// [R14] Reserved selector codes give an inactive low signal.
`timescale 1ns/100ps

module apr_routing
    import apr_pkg::*;
(
    input  wire logic       I_MCLK,
    input  wire logic       I_RESET_N,
    input  wire logic       I_REG_WR,
    input  wire logic       I_REG_RD,
    input  wire logic [6:0] I_REG_ADDR,
    input  wire logic [7:0] I_REG_WDATA,
    output logic      [7:0] O_REG_RDATA,
    input  wire logic [9:0] I_GPIO,
    input  wire logic [2:0] I_GPI,
    input  wire logic       I_SEC_SERIAL_IN,
    input  wire logic       I_SEC_BIT_CLOCK,
    input  wire logic       I_PLL_DIV_CLOCK,
    input  wire logic       I_DAC_MOD_CLOCK,
    input  wire logic       I_ADC_MOD_CLOCK,
    input  wire logic       I_PORT_ACTIVE,
    input  wire logic       I_CODEC_POWERED,
    input  wire logic       I_ISENSE_POWERED,
    input  wire logic       I_PORT_OUT_EN,
    input  wire logic       I_OUT_PATH_DATA,
    output logic            O_BIT_CLOCK,
    output logic            O_WORD_CLOCK,
    output logic            O_CLOCKS_DRIVE,
    output logic            O_SERIAL_IN,
    output logic            O_SERIAL_OUT,
    output logic            O_SERIAL_OUT_OE,
    output logic            O_DIV_CLOCK
);
    import apr_pkg::*;

    // ****************************************************************
    // Pin selection
    // ****************************************************************
    function automatic logic pick_pin(input logic [3:0] code, input logic [9:0] gpio,
                                      input logic [2:0] gpi);
        logic [3:0] idx;
        idx = code - APR_PIN_GPI_FIRST;
        if (code <= APR_PIN_GPIO_LAST) begin
            pick_pin = gpio[code];
        end else if (code >= APR_PIN_GPI_FIRST && code <= APR_PIN_GPI_LAST) begin
            pick_pin = gpi[idx[1:0]];
        end else begin
            pick_pin = 1'b0;
        end
    endfunction : pick_pin

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [14:0] pin_meta_q;
    logic [14:0] pin_sync_q;
    logic [9:0]  gpio_s;
    logic [2:0]  gpi_s;
    logic        sec_in_s;
    logic        sec_bclk_s;

    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            pin_meta_q <= 15'h0000;
            pin_sync_q <= 15'h0000;
        end else begin
            pin_meta_q <= {I_SEC_BIT_CLOCK, I_SEC_SERIAL_IN, I_GPI, I_GPIO};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign gpio_s     = pin_sync_q[9:0];
    assign gpi_s      = pin_sync_q[12:10];
    assign sec_in_s   = pin_sync_q[13];
    assign sec_bclk_s = pin_sync_q[14];

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0] page_q;
    logic [3:0] bit_pin_q;
    logic       bit_pol_q;
    logic       free_run_q;
    logic [3:0] word_pin_q;
    logic       word_pol_q;
    logic [3:0] data_pin_q;
    logic [1:0] out_src_q;
    logic [2:0] div_src_q;
    logic [6:0] ratio_q;
    logic       div_pwr_q;
    logic       on_page;
    logic       wr_page;

    assign on_page = (page_q == APR_ROUTING_PAGE); // [R12]
    assign wr_page = I_REG_WR && on_page;

    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            page_q <= APR_RST_PAGE;
        end else if (I_REG_WR && I_REG_ADDR == APR_ADDR_PAGE) begin
            page_q <= I_REG_WDATA;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            bit_pin_q  <= APR_RST_BIT_PIN; // [R2]
            bit_pol_q  <= 1'b0;
            free_run_q <= 1'b0;
        end else if (wr_page && I_REG_ADDR == APR_ADDR_BIT_CLOCK) begin
            bit_pin_q  <= I_REG_WDATA[APR_PIN_SEL_MSB:APR_PIN_SEL_LSB];
            bit_pol_q  <= I_REG_WDATA[APR_POLARITY_BIT];
            free_run_q <= I_REG_WDATA[APR_FREE_RUN_BIT];
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            word_pin_q <= APR_RST_WORD_PIN; // [R5] [R11]
            word_pol_q <= 1'b0;
        end else if (wr_page && I_REG_ADDR == APR_ADDR_WORD_CLOCK) begin
            word_pin_q <= I_REG_WDATA[APR_PIN_SEL_MSB:APR_PIN_SEL_LSB];
            word_pol_q <= I_REG_WDATA[APR_POLARITY_BIT];
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            data_pin_q <= APR_RST_DATA_PIN;
            out_src_q  <= APR_RST_OUT_SRC;
        end else if (wr_page && I_REG_ADDR == APR_ADDR_DATA_PIN) begin
            data_pin_q <= I_REG_WDATA[APR_PIN_SEL_MSB:APR_PIN_SEL_LSB];
            out_src_q  <= I_REG_WDATA[APR_OUT_SRC_MSB:APR_OUT_SRC_LSB];
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            div_src_q <= APR_RST_DIV_SRC; // [R10]
            ratio_q   <= APR_RST_RATIO;
            div_pwr_q <= APR_RST_DIV_PWR;
        end else if (wr_page && I_REG_ADDR == APR_ADDR_DIV_SRC) begin
            div_src_q <= I_REG_WDATA[APR_DIV_SRC_MSB:APR_DIV_SRC_LSB];
        end else if (wr_page && I_REG_ADDR == APR_ADDR_DIV_RATIO) begin
            ratio_q   <= I_REG_WDATA[APR_RATIO_MSB:APR_RATIO_LSB];
            div_pwr_q <= I_REG_WDATA[APR_DIV_PWR_BIT];
        end
    end

    // Reserved bits and unmapped addresses read as zero
    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            O_REG_RDATA <= 8'h00;
        end else if (I_REG_RD) begin
            if (I_REG_ADDR == APR_ADDR_PAGE) begin
                O_REG_RDATA <= page_q;
            end else if (!on_page) begin
                O_REG_RDATA <= 8'h00;
            end else begin
                case (I_REG_ADDR)
                    APR_ADDR_BIT_CLOCK:  O_REG_RDATA <= {1'b0, bit_pin_q, 1'b0,
                                                         bit_pol_q, free_run_q};
                    APR_ADDR_WORD_CLOCK: O_REG_RDATA <= {1'b0, word_pin_q, 1'b0,
                                                         word_pol_q, 1'b0};
                    APR_ADDR_DATA_PIN:   O_REG_RDATA <= {1'b0, data_pin_q, 1'b0, out_src_q};
                    APR_ADDR_DIV_SRC:    O_REG_RDATA <= {5'h00, div_src_q};
                    APR_ADDR_DIV_RATIO:  O_REG_RDATA <= {div_pwr_q, ratio_q};
                    default:             O_REG_RDATA <= 8'h00;
                endcase
            end
        end
    end

    // ****************************************************************
    // Clock and data routing
    // ****************************************************************
    logic bit_raw;
    logic word_raw;
    logic data_raw;
    logic drive_en;

    assign bit_raw  = pick_pin(bit_pin_q, gpio_s, gpi_s); // [R1] [R14]
    assign word_raw = pick_pin(word_pin_q, gpio_s, gpi_s); // [R5] [R14]
    assign data_raw = pick_pin(data_pin_q, gpio_s, gpi_s); // [R7] [R14]
    assign drive_en = free_run_q || (I_PORT_ACTIVE && I_CODEC_POWERED); // [R4]

    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            O_BIT_CLOCK    <= 1'b0;
            O_WORD_CLOCK   <= 1'b0;
            O_CLOCKS_DRIVE <= 1'b0;
            O_SERIAL_IN    <= 1'b0;
        end else begin
            O_BIT_CLOCK    <= bit_raw ^ bit_pol_q; // [R3]
            O_WORD_CLOCK   <= word_raw ^ word_pol_q; // [R6]
            O_CLOCKS_DRIVE <= drive_en; // [R4]
            O_SERIAL_IN    <= data_raw;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            O_SERIAL_OUT    <= 1'b0;
            O_SERIAL_OUT_OE <= 1'b0;
        end else begin
            case (apr_out_src_t'(out_src_q))
                APR_OUT_NORMAL_SENSE: begin
                    O_SERIAL_OUT    <= I_OUT_PATH_DATA; // [R8]
                    O_SERIAL_OUT_OE <= I_PORT_OUT_EN && I_ISENSE_POWERED;
                end
                APR_OUT_LOOP_PRIMARY: begin
                    O_SERIAL_OUT    <= data_raw; // [R9]
                    O_SERIAL_OUT_OE <= I_PORT_OUT_EN;
                end
                APR_OUT_LOOP_SECONDARY: begin
                    O_SERIAL_OUT    <= sec_in_s; // [R9]
                    O_SERIAL_OUT_OE <= I_PORT_OUT_EN;
                end
                default: begin
                    O_SERIAL_OUT    <= I_OUT_PATH_DATA; // [R8]
                    O_SERIAL_OUT_OE <= I_PORT_OUT_EN;
                end
            endcase
        end
    end

    // ****************************************************************
    // Bit clock divider
    // ****************************************************************
    logic       div_src;
    logic       div_src_prev_q;
    logic [7:0] div_count_q;
    logic [7:0] div_n;

    always_comb begin
        case (apr_div_src_t'(div_src_q))
            APR_DIV_PLL:           div_src = I_PLL_DIV_CLOCK; // [R10]
            APR_DIV_DAC_MOD:       div_src = I_DAC_MOD_CLOCK;
            APR_DIV_ADC_MOD:       div_src = I_ADC_MOD_CLOCK;
            APR_DIV_PRIMARY_PIN:   div_src = bit_raw;
            APR_DIV_SECONDARY_PIN: div_src = sec_bclk_s;
            default:               div_src = 1'b0; // [R14]
        endcase
    end

    assign div_n = (ratio_q == 7'h00) ? APR_DIV_FULL : {1'b0, ratio_q}; // [R13]

    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            div_src_prev_q <= 1'b0;
            div_count_q    <= 8'h00;
            O_DIV_CLOCK    <= 1'b0;
        end else if (!div_pwr_q) begin
            div_src_prev_q <= div_src;
            div_count_q    <= 8'h00;
            O_DIV_CLOCK    <= 1'b0;
        end else begin
            div_src_prev_q <= div_src;
            if (div_src && !div_src_prev_q) begin
                div_count_q <= (div_count_q >= div_n - 8'h01) ? 8'h00 : div_count_q + 8'h01;
            end
            if (div_n == 8'h01) begin
                O_DIV_CLOCK <= div_src;
            end else begin
                O_DIV_CLOCK <= (div_count_q < {1'b0, div_n[7:1]}); // [R13]
            end
        end
    end

endmodule : apr_routing

//--- verif/apr_routing_properties.sv
// Checker on the routing block ports: reset, register readback, routing.
// Assumes it is bound to every apr_routing instance.
`timescale 1ns/100ps
module apr_routing_properties
    import apr_pkg::*;
(
    input wire logic       I_MCLK,
    input wire logic       I_RESET_N,
    input wire logic       I_REG_WR,
    input wire logic       I_REG_RD,
    input wire logic [6:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic [7:0] O_REG_RDATA,
    input wire logic [9:0] I_GPIO,
    input wire logic [2:0] I_GPI,
    input wire logic       I_PORT_ACTIVE,
    input wire logic       I_CODEC_POWERED,
    input wire logic       O_BIT_CLOCK,
    input wire logic       O_WORD_CLOCK,
    input wire logic       O_CLOCKS_DRIVE,
    input wire logic       O_SERIAL_IN
);
    // ****************************************************************
    // Register mirror and properties
    // ****************************************************************
    logic [7:0] pg_q;
    logic [7:0] bc_q;
    logic       pg_ok;
    assign pg_ok = pg_q == APR_ROUTING_PAGE;
    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            pg_q <= APR_RST_PAGE;
            bc_q <= 8'h00;
        end else if (I_REG_WR && I_REG_ADDR == APR_ADDR_PAGE) begin
            pg_q <= I_REG_WDATA;
        end else if (I_REG_WR && I_REG_ADDR == APR_ADDR_BIT_CLOCK && pg_ok) begin
            bc_q <= I_REG_WDATA & 8'h7B;
        end
    end
    function automatic logic pin_at(logic [3:0] c, logic [9:0] g, logic [2:0] p);
        if (c <= APR_PIN_GPIO_LAST) return g[c];
        if (c >= APR_PIN_GPI_FIRST && c <= APR_PIN_GPI_LAST) return p[c - APR_PIN_GPI_FIRST];
        return 1'h0;
    endfunction : pin_at
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RESET_N);
    sequence s_bc_read;
        I_REG_RD && I_REG_ADDR == APR_ADDR_BIT_CLOCK && pg_ok;
    endsequence
    chk_reset_clears: assert property (disable iff (1'h0) !I_RESET_N |=>
        !{O_BIT_CLOCK, O_WORD_CLOCK, O_CLOCKS_DRIVE, O_SERIAL_IN, O_REG_RDATA})
        else $error("outputs not cleared by reset");
    chk_bit_readback: assert property (s_bc_read |=> O_REG_RDATA == $past(bc_q))
        else $error("bit clock register readback wrong");
    chk_rdata_holds: assert property (!I_REG_RD |=> $stable(O_REG_RDATA))
        else $error("read data changed without a read");
    chk_word_reserved: assert property (I_REG_RD && I_REG_ADDR == APR_ADDR_WORD_CLOCK |=>
        (O_REG_RDATA & 8'h85) == 8'h00)
        else $error("word clock reserved bits set");
    chk_div_reserved: assert property (I_REG_RD && I_REG_ADDR == APR_ADDR_DIV_SRC |=>
        O_REG_RDATA[7:3] == 5'h00)
        else $error("divider source reserved bits set");
    chk_page_refuse: assert property (I_REG_RD && I_REG_ADDR != APR_ADDR_PAGE && !pg_ok
        |=> O_REG_RDATA == 8'h00)
        else $error("read off the routing page not zero");
    chk_drive_enable: assert property ($past(I_RESET_N) |-> O_CLOCKS_DRIVE ==
        $past(bc_q[APR_FREE_RUN_BIT] | I_PORT_ACTIVE & I_CODEC_POWERED))
        else $error("clock drive enable wrong");
    chk_bit_clock_path: assert property ($past(I_RESET_N, 3)
        && $past(I_RESET_N, 2) && $past(I_RESET_N)
        |-> O_BIT_CLOCK == (pin_at($past(bc_q[6:3]), $past(I_GPIO, 3),
        $past(I_GPI, 3)) ^ $past(bc_q[APR_POLARITY_BIT])))
        else $error("bit clock not from selected pin");
endmodule : apr_routing_properties

bind apr_routing apr_routing_properties chk (.I_MCLK, .I_RESET_N, .I_REG_WR, .I_REG_RD,
    .I_REG_ADDR, .I_REG_WDATA, .O_REG_RDATA, .I_GPIO, .I_GPI, .I_PORT_ACTIVE,
    .I_CODEC_POWERED, .O_BIT_CLOCK, .O_WORD_CLOCK, .O_CLOCKS_DRIVE, .O_SERIAL_IN);

//--- verif/apr_host_model.sv
// Host serial port model driving the port pins.
// Assumes the bench gives idle pin levels; a frame runs while i_run is high.
`timescale 1ns/100ps
module apr_host_model (
    input  wire logic        i_clk,
    input  wire logic        i_run,
    input  wire logic [12:0] i_level,
    output logic      [9:0]  o_gpio,
    output logic      [2:0]  o_gpi
);
    // ****************************************************************
    // Frame pattern, clocks stand still outside frames
    // ****************************************************************
    logic [4:0] cnt_q;
    always_ff @(posedge i_clk) cnt_q <= i_run ? cnt_q + 5'h01 : 5'h00;
    always_comb begin
        {o_gpi, o_gpio} = i_level;
        if (i_run) begin
            o_gpio[0] = cnt_q[0];
            o_gpio[1] = cnt_q[4];
            o_gpi[0]  = cnt_q[1] ^ cnt_q[3];
        end
    end
endmodule : apr_host_model

//--- verif/testbench.sv
// Self-checking bench for apr_routing.
// Assumes apr_host_model on the port pins and the checker bound.
`timescale 1ns/100ps
module testbench;
    import apr_pkg::*;
    // ****************************************************************
    // Stimulus, scenarios and checks
    // ****************************************************************
    logic        clk = '0, rst_n = '0, wr_s = '0, rd_s = '0, run = '0, tog = '0;
    logic        act = '0, pwr = '0, isen = '0, oen = '0, odata = '0, sec_in = '0;
    logic [6:0]  addr = '0;
    logic [7:0]  wdata = '0, rdata, rv;
    logic [12:0] level = '0;
    logic [2:0]  dsel = '0, gpi;
    logic [9:0]  gpio;
    logic        bclk, wclk, drv, sin, sout, soe, divc;
    int          fail_count = 0, tests_run = 0;
    initial forever #2 clk = ~clk;
    always @(posedge clk) tog <= ~tog;
    apr_host_model host (.i_clk(clk), .i_run(run), .i_level(level), .o_gpio(gpio), .o_gpi(gpi));
    apr_routing uut (.I_MCLK(clk), .I_RESET_N(rst_n), .I_REG_WR(wr_s), .I_REG_RD(rd_s),
        .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .I_GPIO(gpio),
        .I_GPI(gpi), .I_SEC_SERIAL_IN(sec_in), .I_SEC_BIT_CLOCK(dsel == 3'h6 && tog),
        .I_PLL_DIV_CLOCK(dsel == 3'h0 && tog), .I_DAC_MOD_CLOCK(dsel == 3'h1 && tog),
        .I_ADC_MOD_CLOCK(dsel == 3'h3 && tog), .I_PORT_ACTIVE(act), .I_CODEC_POWERED(pwr),
        .I_ISENSE_POWERED(isen), .I_PORT_OUT_EN(oen), .I_OUT_PATH_DATA(odata),
        .O_BIT_CLOCK(bclk), .O_WORD_CLOCK(wclk), .O_CLOCKS_DRIVE(drv), .O_SERIAL_IN(sin),
        .O_SERIAL_OUT(sout), .O_SERIAL_OUT_OE(soe), .O_DIV_CLOCK(divc));
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(logic [6:0] a, logic [7:0] d);
        @(posedge clk); #1;
        {wr_s, addr, wdata} = {1'h1, a, d};
        @(posedge clk); #1;
        wr_s = 1'h0;
    endtask : wr
    task automatic rd(logic [6:0] a, output logic [7:0] d);
        @(posedge clk); #1;
        {rd_s, addr} = {1'h1, a};
        @(posedge clk); #1;
        rd_s = 1'h0;
        d = rdata;
    endtask : rd
    task automatic t_regs;
        logic [6:0] a[7] = '{7'h00, 7'h08, 7'h09, 7'h0C, 7'h0D, 7'h0E, 7'h0A};
        logic [7:0] e[7] = '{8'h01, 8'h00, 8'h08, 8'h00, 8'h01, 8'h02, 8'h00};
        for (int i = 0; i < 7; i++) begin
            rd(a[i], rv);
            chk("reset value", e[i], rv);
        end
        wr(APR_ADDR_PAGE, 8'h02);
        wr(APR_ADDR_BIT_CLOCK, 8'h7B);
        rd(APR_ADDR_BIT_CLOCK, rv);
        chk("other page", 8'h00, rv);
        wr(APR_ADDR_PAGE, APR_ROUTING_PAGE);
        rd(APR_ADDR_BIT_CLOCK, rv);
        chk("ignored write", 8'h00, rv);
        wr(APR_ADDR_BIT_CLOCK, 8'hFF);
        wr(7'h0A, 8'hFF);
        rd(APR_ADDR_BIT_CLOCK, rv);
        chk("bit clock reg", 8'h7B, rv);
        rd(7'h0A, rv);
        chk("unmapped", 8'h00, rv);
        $display("test regs done");
    endtask : t_regs
    task automatic t_pins;
        int h;
        for (int c = 0; c < 16; c++) for (int p = 0; p < 2; p++) begin
            h = c <= 9 ? c : (c >= 12 && c <= 14 ? c - 2 : -1);
            level = h < 0 ? 13'h1FFF : 13'h0001 << h;
            wr(APR_ADDR_BIT_CLOCK, {1'h0, c[3:0], 1'h0, p[0], 1'h0});
            wr(APR_ADDR_WORD_CLOCK, {1'h0, c[3:0], 1'h0, p[0], 1'h0});
            wr(APR_ADDR_DATA_PIN, {1'h0, c[3:0], 3'h0});
            @(posedge clk); #1;
            chk("bit clock", 8'((h >= 0) ^ p[0]), 8'(bclk));
            chk("word clock", 8'((h >= 0) ^ p[0]), 8'(wclk));
            chk("serial in", 8'(h >= 0), 8'(sin));
        end
        $display("test pins done");
    endtask : t_pins
    task automatic t_drive;
        for (int i = 0; i < 8; i++) begin
            wr(APR_ADDR_BIT_CLOCK, {7'h00, i[0]});
            {pwr, act} = i[2:1];
            @(posedge clk); #1;
            chk("drive", 8'(i[0] | (i[1] & i[2])), 8'(drv));
        end
        $display("test drive done");
    endtask : t_drive
    task automatic t_out;
        for (int s = 0; s < 4; s++) for (int p = 0; p < 32; p++) begin
            {oen, isen, sec_in, odata} = p[3:0];
            level = {2'h0, p[4], 10'h000};
            wr(APR_ADDR_DATA_PIN, {6'h18, s[1:0]});
            repeat (2) @(posedge clk);
            #1;
            chk("serial out", 8'(s == 1 ? p[4] : s == 2 ? p[1] : p[0]), 8'(sout));
            chk("out enable", 8'(s == 0 ? p[3] & p[2] : p[3]), 8'(soe));
        end
        $display("test out done");
    endtask : t_out
    task automatic t_div(logic [2:0] s, logic [6:0] r, logic on, int e);
        int   n, cnt;
        logic prev;
        n = r == 7'h00 ? 128 : r;
        {dsel, run, level} = {s, s == 3'h4, 13'h0000};
        wr(APR_ADDR_DIV_SRC, {5'h00, s});
        wr(APR_ADDR_DIV_RATIO, {on, r});
        repeat (8) @(posedge clk);
        #1;
        cnt = 0;
        prev = divc;
        repeat (32 * n) begin
            @(posedge clk);
            #1;
            cnt += (divc === 1'h1 && prev === 1'h0);
            prev = divc;
        end
        cnt = (e > 0 && cnt >= e - 1 && cnt <= e + 1) ? e : cnt;
        chk("divider", 8'(e), 8'(cnt));
        $display("test div done");
    endtask : t_div
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    initial begin
        #200000;
        fail_count++;
        summarize;
    end
    initial begin
        repeat (4) @(posedge clk);
        #1 rst_n = 1'h1;
        t_regs;
        t_pins;
        t_drive;
        t_out;
        for (int k = 0; k < 8; k++) t_div(k[2:0], 7'h04, 1'h1, k inside {2, 5, 7} ? 0 : 16);
        t_div(3'h0, 7'h00, 1'h1, 16);
        t_div(3'h0, 7'h03, 1'h1, 16);
        t_div(3'h0, 7'h01, 1'h1, 16);
        t_div(3'h0, 7'h04, 1'h0, 0);
        summarize;
    end
endmodule : testbench
